/* sfto_pkg.sv */
// shared constants and carriers for the fma and thread-op decoder
package sfto_pkg;
    // instruction field layout
    localparam int OP_HI = 31;
    localparam int OP_LO = 30;
    localparam int RD_HI = 29;
    localparam int RD_LO = 25;
    localparam int OP3_HI = 24;
    localparam int OP3_LO = 19;
    localparam int RS1_HI = 18;
    localparam int RS1_LO = 14;
    localparam int RS3_HI = 13;
    localparam int RS3_LO = 9;
    localparam int VAR_HI = 8;
    localparam int VAR_LO = 7;
    localparam int SIZE_HI = 6;
    localparam int SIZE_LO = 5;
    localparam int RS2_HI = 4;
    localparam int RS2_LO = 0;
    localparam int OPF_HI = 13;
    localparam int OPF_LO = 5;
    // encodings
    localparam logic [1:0] OP_ARITH = 2'h2;
    localparam logic [5:0] OP3_IMPDEP_A = 6'h36;
    localparam logic [5:0] OP3_IMPDEP_B = 6'h37;
    localparam logic [8:0] OPF_SUSPEND = 9'h082;
    localparam logic [8:0] OPF_SLEEP = 9'h083;
    localparam logic [1:0] SIZE_INT = 2'h0;
    localparam logic [1:0] SIZE_QUAD = 2'h3;
    localparam logic [1:0] VAR_LOW = 2'h0;
    localparam logic [1:0] VAR_HIGH = 2'h1;
    localparam logic [1:0] VAR_ALL = 2'h3;
    // register port map
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CTRL_PREWAKE_BIT = 0;
    // sleep timeout, measured on the system tick
    localparam int SLEEP_TIMEOUT_NS = 1600;
    localparam int TICK_PERIOD_NS = 100;
    localparam int SLEEP_TICKS = SLEEP_TIMEOUT_NS / TICK_PERIOD_NS;

    typedef enum logic [2:0] {
        K_NONE, K_FMA, K_IMADD_LO, K_IMADD_HI, K_SUSPEND, K_SLEEP
    } sfto_kind_t;

    typedef struct packed {
        logic       valid;
        logic       simd;
        logic [2:0] u_src1;
        logic [2:0] u_src2;
        logic [2:0] u_addend;
        logic [2:0] u_dst;
    } sfto_prefix_t;

    typedef struct packed {
        logic [8:0] src1;
        logic [8:0] src2;
        logic [8:0] addend;
        logic [8:0] dst;
        logic       negate;
    } sfto_half_t;

    typedef struct packed {
        sfto_kind_t kind;
        logic       ext_en;
        sfto_half_t basic;
        sfto_half_t ext;
        logic       fsr_update;
        logic       ill_instr;
        logic       ill_action;
        logic       priv_trap;
        logic       fp_disabled;
        logic       ie_set;
    } sfto_dec_t;
endpackage

/* sfto_core.sv */
// decoder and thread-state control for simd fma, integer multiply-add, suspend and sleep
// Function
// (RULE1) basic and extended halves are issued as two independent operations
// (RULE2) with simd flag clear all four register fields reach any register
// (RULE3) simd sources 2n; extended half reads (2n+256) mod 512
// (RULE4) simd addend/destination: basic 0..254, extended 256..510
// (RULE5) top bits of addend/destination fields forced 0 basic, 1 extended
// (RULE6) addend-field top bit set: extended multiply uses basic first source
// (RULE7) destination-field top bit set: extended product negated
// (RULE8) extended source indices use inverted top bit of upper field
// (RULE9) size 11 with variant not 11 is illegal; fp-disabled check skipped
// (RULE10) suspend sets interrupt enable and suspends the thread
// (RULE11) suspended thread resumes only on resets or interrupts
// (RULE12) sleep halts the thread; resets or interrupts wake it
// (RULE13) sleeping thread wakes after about 1.6 us of system ticks
// (RULE14) window-mapped barrier flag update wakes sleeper; others do not
// (RULE15) sleep issued with interrupts disabled ignores interrupts
// (RULE16) barrier flag update while awake lets next sleep fall through
// (RULE17) integer multiply-add is unsigned 64-bit fused product plus addend
// (RULE18) variant 00 size 00 writes low 64 bits of the result
// (RULE19) variant 01 size 00 writes high 64 bits of the result
// (RULE20) integer multiply-add never updates the fp state register
// (RULE21) simd integer multiply-add with any upper top bit set is illegal action
// (RULE22) integer multiply-add fields decoded at fixed bit positions
`timescale 1ns/1ps
module sfto_core
    import sfto_pkg::*;
#(
    parameter int TIMEOUT_TICKS = SLEEP_TICKS
) (
    // clock and reset
    input  wire logic         CLK,
    input  wire logic         SYS_RST,
    // issue side
    input  wire logic         ISSUE_VALID,
    input  wire logic [31:0]  ISSUE_INSTR,
    input  wire sfto_prefix_t ISSUE_PREFIX,
    input  wire logic         PRIV_MODE,
    input  wire logic         FP_ENABLED,
    input  wire logic         INT_ENABLE,
    input  wire logic [63:0]  OPND_SRC1,
    input  wire logic [63:0]  OPND_SRC2,
    input  wire logic [63:0]  OPND_ADDEND,
    // wake sources
    input  wire logic         WATCHDOG_RESET_EVENT,
    input  wire logic         EXTERNAL_INITIATED_RESET,
    input  wire logic         INT_VECTOR,
    input  wire logic         INT_LEVEL,
    input  wire logic         SYSTEM_TICK,
    input  wire logic         BARRIER_SYNC_UPDATE,
    input  wire logic         BARRIER_SYNC_WINDOW,
    // register port
    input  wire logic [3:0]   REG_ADDR,
    input  wire logic [31:0]  REG_WDATA,
    input  wire logic         REG_WR,
    input  wire logic         REG_RD,
    output logic [31:0]       REG_RDATA,
    // decode and result
    output logic              DEC_VALID,
    output sfto_dec_t         DEC_OUT,
    output logic              MADD_VALID,
    output logic [63:0]       MADD_RESULT,
    output logic [8:0]        MADD_DST,
    // thread state
    output logic              THREAD_HALTED
);

    typedef enum logic [1:0] {S_RUN, S_SUSPENDED, S_SLEEPING} sfto_state_t;

    // double register number from a 3-bit upper field and a 5-bit field
    function automatic logic [8:0] dp_index(input logic [2:0] u, input logic [4:0] f);
        dp_index = {u, f[0], f[4:1], 1'b0};
    endfunction

    sfto_state_t state_reg;
    sfto_state_t state_next;
    logic        sleep_ie_reg;
    logic        prewake_reg;
    logic [15:0] tick_cnt_reg;
    logic [31:0] ctrl_reg;
    sfto_dec_t   dec_next;

    // field split (RULE22)
    logic [1:0] f_op;
    logic [5:0] f_op3;
    logic [4:0] f_rd;
    logic [4:0] f_rs1;
    logic [4:0] f_rs2;
    logic [4:0] f_rs3;
    logic [1:0] f_var;
    logic [1:0] f_size;
    logic [8:0] f_opf;
    assign f_op   = ISSUE_INSTR[OP_HI:OP_LO]; // RULE22
    assign f_rd   = ISSUE_INSTR[RD_HI:RD_LO];
    assign f_op3  = ISSUE_INSTR[OP3_HI:OP3_LO];
    assign f_rs1  = ISSUE_INSTR[RS1_HI:RS1_LO];
    assign f_rs3  = ISSUE_INSTR[RS3_HI:RS3_LO];
    assign f_var  = ISSUE_INSTR[VAR_HI:VAR_LO];
    assign f_size = ISSUE_INSTR[SIZE_HI:SIZE_LO];
    assign f_rs2  = ISSUE_INSTR[RS2_HI:RS2_LO];
    assign f_opf  = ISSUE_INSTR[OPF_HI:OPF_LO];

    logic take;
    logic is_b;
    logic is_a;
    logic simd_on;
    logic any_top;
    logic [2:0] u1;
    logic [2:0] u2;
    logic [2:0] u3;
    logic [2:0] ud;
    // a halted thread issues nothing, so requests then are dropped
    assign take    = ISSUE_VALID && (state_reg == S_RUN);
    assign is_b    = (f_op == OP_ARITH) && (f_op3 == OP3_IMPDEP_B);
    assign is_a    = (f_op == OP_ARITH) && (f_op3 == OP3_IMPDEP_A);
    assign simd_on = ISSUE_PREFIX.valid && ISSUE_PREFIX.simd;
    // without a prefix the upper fields are zero
    assign u1 = ISSUE_PREFIX.valid ? ISSUE_PREFIX.u_src1 : 3'h0;
    assign u2 = ISSUE_PREFIX.valid ? ISSUE_PREFIX.u_src2 : 3'h0;
    assign u3 = ISSUE_PREFIX.valid ? ISSUE_PREFIX.u_addend : 3'h0;
    assign ud = ISSUE_PREFIX.valid ? ISSUE_PREFIX.u_dst : 3'h0;
    assign any_top = u1[2] | u2[2] | u3[2] | ud[2];

    // combinational decode of one issued word
    always_comb begin
        dec_next = '0;
        dec_next.kind = K_NONE;
        // basic half: full upper fields when not simd (RULE2)
        dec_next.basic.src1   = dp_index(u1, f_rs1); // RULE8
        dec_next.basic.src2   = dp_index(u2, f_rs2); // RULE8
        dec_next.basic.addend = dp_index(u3, f_rs3); // RULE2
        dec_next.basic.dst    = dp_index(ud, f_rd); // RULE2
        if (is_b) begin
            if ((f_size == SIZE_QUAD) && (f_var != VAR_ALL)) begin
                dec_next.ill_instr = 1'b1; // RULE9
            end else if (f_size == SIZE_INT) begin
                dec_next.kind = (f_var == VAR_HIGH) ? K_IMADD_HI : K_IMADD_LO; // RULE18
                dec_next.fp_disabled = !FP_ENABLED;
                dec_next.ill_action = simd_on && any_top; // RULE21
                dec_next.ext_en = simd_on;
                dec_next.fsr_update = 1'b0; // RULE20
                if (f_var[1]) begin
                    dec_next.kind = K_NONE; // other variants decoded elsewhere
                end
            end else if (f_size != SIZE_QUAD) begin
                dec_next.kind = K_FMA;
                dec_next.fp_disabled = !FP_ENABLED;
                dec_next.fsr_update = 1'b1;
                dec_next.ext_en = simd_on;
            end
            // simd split into two independent halves (RULE1)
            if (simd_on) begin
                dec_next.basic.addend = {1'b0, u3[1:0], f_rs3[0], f_rs3[4:1], 1'b0}; // RULE5
                dec_next.basic.dst    = {1'b0, ud[1:0], f_rd[0], f_rd[4:1], 1'b0}; // RULE4
                dec_next.ext.addend   = {1'b1, u3[1:0], f_rs3[0], f_rs3[4:1], 1'b0}; // RULE5
                dec_next.ext.dst      = {1'b1, ud[1:0], f_rd[0], f_rd[4:1], 1'b0}; // RULE4
                // inverted top bit is the (2n+256) mod 512 partner
                dec_next.ext.src1 = dp_index({~u1[2], u1[1:0]}, f_rs1); // RULE3 RULE8
                dec_next.ext.src2 = dp_index({~u2[2], u2[1:0]}, f_rs2); // RULE3 RULE8
                if ((dec_next.kind == K_FMA) && u3[2]) begin
                    dec_next.ext.src1 = dec_next.basic.src1; // RULE6
                end
                dec_next.ext.negate = (dec_next.kind == K_FMA) && ud[2]; // RULE7
            end
        end else if (is_a && (f_opf == OPF_SUSPEND)) begin
            dec_next.kind = K_SUSPEND;
            dec_next.priv_trap = !PRIV_MODE;
            dec_next.ill_action = ISSUE_PREFIX.valid;
            dec_next.ie_set = PRIV_MODE && !ISSUE_PREFIX.valid; // RULE10
        end else if (is_a && (f_opf == OPF_SLEEP)) begin
            dec_next.kind = K_SLEEP;
            dec_next.ill_action = ISSUE_PREFIX.valid;
        end
        // an illegal word never checks fp-disabled (RULE9)
        if (dec_next.ill_instr) begin
            dec_next.fp_disabled = 1'b0; // RULE9
        end
    end

    logic no_trap;
    assign no_trap = !(dec_next.ill_instr | dec_next.ill_action | dec_next.priv_trap
                       | dec_next.fp_disabled);

    // registered decode output
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            DEC_VALID <= 1'b0;
            DEC_OUT   <= '0;
        end else begin
            DEC_VALID <= take;
            DEC_OUT   <= take ? dec_next : '0;
        end
    end

    // fused unsigned multiply-add, unrounded 128-bit sum (RULE17)
    logic [127:0] madd_full;
    assign madd_full = (128'(OPND_SRC1) * 128'(OPND_SRC2)) + 128'(OPND_ADDEND); // RULE17

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MADD_VALID  <= 1'b0;
            MADD_RESULT <= 64'h0;
            MADD_DST    <= 9'h000;
        end else begin
            MADD_VALID <= take && no_trap
                          && ((dec_next.kind == K_IMADD_LO) || (dec_next.kind == K_IMADD_HI));
            MADD_DST   <= dec_next.basic.dst;
            if (dec_next.kind == K_IMADD_HI) begin
                MADD_RESULT <= madd_full[127:64]; // RULE19
            end else begin
                MADD_RESULT <= madd_full[63:0]; // RULE18
            end
        end
    end

    // wake terms; power-on reset is SYS_RST itself
    logic rst_wake;
    logic int_wake;
    logic bar_wake;
    logic timed_out;
    assign rst_wake  = WATCHDOG_RESET_EVENT || EXTERNAL_INITIATED_RESET;
    assign int_wake  = INT_VECTOR || INT_LEVEL;
    assign bar_wake  = BARRIER_SYNC_UPDATE && BARRIER_SYNC_WINDOW; // RULE14
    assign timed_out = SYSTEM_TICK && (tick_cnt_reg >= 16'(TIMEOUT_TICKS - 1));

    logic go_suspend;
    logic go_sleep;
    assign go_suspend = take && (dec_next.kind == K_SUSPEND) && no_trap;
    assign go_sleep   = take && (dec_next.kind == K_SLEEP) && no_trap;

    // thread state transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_RUN: begin
                if (go_suspend) begin
                    state_next = S_SUSPENDED; // RULE10
                end else if (go_sleep && !(prewake_reg && ctrl_reg[CTRL_PREWAKE_BIT])) begin
                    state_next = S_SLEEPING; // RULE12 RULE16
                end
            end
            S_SUSPENDED: begin
                if (rst_wake || int_wake) begin
                    state_next = S_RUN; // RULE11
                end
            end
            S_SLEEPING: begin
                if (rst_wake || (int_wake && sleep_ie_reg) || timed_out || bar_wake) begin
                    state_next = S_RUN; // RULE12 RULE13 RULE14 RULE15
                end
            end
            default: state_next = S_RUN;
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg     <= S_RUN;
            THREAD_HALTED <= 1'b0;
        end else begin
            state_reg     <= state_next;
            THREAD_HALTED <= (state_next != S_RUN);
        end
    end

    // interrupt enable seen when sleep was issued (RULE15)
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sleep_ie_reg <= 1'b0;
        end else if (go_sleep) begin
            sleep_ie_reg <= INT_ENABLE; // RULE15
        end
    end

    // barrier update while awake arms a fall-through; set beats the clear
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            prewake_reg <= 1'b0;
        end else if ((state_reg == S_RUN) && bar_wake) begin
            prewake_reg <= 1'b1; // RULE16
        end else if (go_sleep) begin
            prewake_reg <= 1'b0;
        end
    end

    // timeout counts system ticks, not core clocks, so it tracks real time
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tick_cnt_reg <= 16'h0000;
        end else if (state_reg != S_SLEEPING) begin
            tick_cnt_reg <= 16'h0000;
        end else if (SYSTEM_TICK) begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001; // RULE13
        end
    end

    // control register
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_reg <= CTRL_RESET;
        end else if (REG_WR && (REG_ADDR == ADDR_CTRL)) begin
            ctrl_reg <= {31'h0, REG_WDATA[CTRL_PREWAKE_BIT]};
        end
    end

    // read data valid in the cycle after the strobe only
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (!REG_RD) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_ADDR == ADDR_CTRL) begin
            REG_RDATA <= ctrl_reg;
        end else if (REG_ADDR == ADDR_STAT) begin
            REG_RDATA <= {28'h0, prewake_reg, sleep_ie_reg, state_reg};
        end else begin
            REG_RDATA <= 32'h0000_0000; // unmapped reads zero
        end
    end

    // assertions
    property p_ext_addend_high;
        @(posedge CLK) disable iff (SYS_RST)
        DEC_VALID && DEC_OUT.ext_en |-> DEC_OUT.ext.addend[8] && !DEC_OUT.basic.addend[8];
    endproperty
    a_ext_addend_high: assert property (p_ext_addend_high) else $error("addend halves wrong"); // RULE5

    property p_ext_src_partner;
        @(posedge CLK) disable iff (SYS_RST)
        DEC_VALID && DEC_OUT.ext_en |->
            DEC_OUT.ext.src2 == (DEC_OUT.basic.src2 ^ 9'h100);
    endproperty
    a_ext_src_partner: assert property (p_ext_src_partner) else $error("ext src2 not partner"); // RULE3

    property p_illegal_no_fpdis;
        @(posedge CLK) disable iff (SYS_RST)
        DEC_VALID && DEC_OUT.ill_instr |-> !DEC_OUT.fp_disabled && DEC_OUT.kind == K_NONE;
    endproperty
    a_illegal_no_fpdis: assert property (p_illegal_no_fpdis) else $error("fp check on illegal"); // RULE9

    property p_imadd_no_fsr;
        @(posedge CLK) disable iff (SYS_RST)
        DEC_VALID && (DEC_OUT.kind inside {K_IMADD_LO, K_IMADD_HI}) |-> !DEC_OUT.fsr_update;
    endproperty
    a_imadd_no_fsr: assert property (p_imadd_no_fsr) else $error("fsr updated by imadd"); // RULE20

    property p_madd_low;
        @(posedge CLK) disable iff (SYS_RST)
        MADD_VALID && DEC_OUT.kind == K_IMADD_LO |->
            MADD_RESULT == 64'($past(OPND_SRC1) * $past(OPND_SRC2) + $past(OPND_ADDEND));
    endproperty
    a_madd_low: assert property (p_madd_low) else $error("low madd result wrong"); // RULE18

    property p_suspend_halts;
        @(posedge CLK) disable iff (SYS_RST)
        go_suspend |=> THREAD_HALTED && DEC_OUT.ie_set;
    endproperty
    a_suspend_halts: assert property (p_suspend_halts) else $error("suspend did not halt"); // RULE10

    property p_suspend_stays;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == S_SUSPENDED && !rst_wake && !int_wake |=> state_reg == S_SUSPENDED;
    endproperty
    a_suspend_stays: assert property (p_suspend_stays) else $error("suspend left early"); // RULE11

    property p_sleep_masked_int;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == S_SLEEPING && !sleep_ie_reg && !rst_wake && !timed_out && !bar_wake
            |=> state_reg == S_SLEEPING;
    endproperty
    a_sleep_masked_int: assert property (p_sleep_masked_int) else $error("masked wake"); // RULE15

    property p_barrier_wake;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == S_SLEEPING && bar_wake |=> state_reg == S_RUN && !THREAD_HALTED;
    endproperty
    a_barrier_wake: assert property (p_barrier_wake) else $error("barrier did not wake"); // RULE14

    property p_timeout_bound;
        @(posedge CLK) disable iff (SYS_RST)
        state_reg == S_SLEEPING |-> tick_cnt_reg < 16'(TIMEOUT_TICKS);
    endproperty
    a_timeout_bound: assert property (p_timeout_bound) else $error("sleep overran timeout"); // RULE13

endmodule

/* sfto_far_model.sv */
// far-side model: fp register file read ports and a free-running system tick
`timescale 1ns/1ps
module sfto_far_model #(
    parameter int TICK_DIV = 4
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // register file reads
    input  wire logic [2:0][8:0]  RD_IDX,
    output logic      [2:0][63:0] RD_DATA,
    // system tick
    output logic             SYSTEM_TICK
);
    logic [7:0] div_reg;

    // contents are the inverse of the index, so neighbours never alias
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            RD_DATA[i] = ~{55'h0, RD_IDX[i]};
        end
    end

    // tick runs free, even while no thread sleeps
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_reg     <= 8'h00;
            SYSTEM_TICK <= 1'b0;
        end else begin
            SYSTEM_TICK <= (div_reg == 8'(TICK_DIV - 1));
            div_reg     <= (div_reg == 8'(TICK_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
        end
    end
endmodule

/* tb_top.sv */
// self-checking bench for the fma and thread-op decoder
`timescale 1ns/1ps
module tb_top;
    import sfto_pkg::*;
    localparam int TO  = 3;
    localparam int DIV = 4;
    localparam logic [31:0] W_SLP = {OP_ARITH, 5'h00, OP3_IMPDEP_A, 5'h00, OPF_SLEEP, 5'h00};
    localparam logic [31:0] W_SUS = {OP_ARITH, 5'h00, OP3_IMPDEP_A, 5'h00, OPF_SUSPEND, 5'h00};
    logic             clk, rst, iv, priv, fpen, ie, bupd, bwin, wr, rd, dv, mv, halt, tick;
    logic [31:0]      instr, wdata, rdata, rv;
    logic [3:0]       wk, raddr;
    logic [63:0]      mres;
    logic [8:0]       mdst;
    logic [2:0][8:0]  idx;
    logic [2:0][63:0] opnd;
    sfto_prefix_t     pfx;
    sfto_dec_t        dec;
    int               num_errors, compares;

    sfto_core #(.TIMEOUT_TICKS(TO)) dut (
        .CLK(clk), .SYS_RST(rst), .ISSUE_VALID(iv), .ISSUE_INSTR(instr), .ISSUE_PREFIX(pfx),
        .PRIV_MODE(priv), .FP_ENABLED(fpen), .INT_ENABLE(ie), .OPND_SRC1(opnd[0]),
        .OPND_SRC2(opnd[1]), .OPND_ADDEND(opnd[2]), .WATCHDOG_RESET_EVENT(wk[0]),
        .EXTERNAL_INITIATED_RESET(wk[1]), .INT_VECTOR(wk[2]), .INT_LEVEL(wk[3]),
        .SYSTEM_TICK(tick), .BARRIER_SYNC_UPDATE(bupd), .BARRIER_SYNC_WINDOW(bwin),
        .REG_ADDR(raddr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .DEC_VALID(dv), .DEC_OUT(dec), .MADD_VALID(mv), .MADD_RESULT(mres),
        .MADD_DST(mdst), .THREAD_HALTED(halt));
    sfto_far_model #(.TICK_DIV(DIV)) far (
        .CLK(clk), .SYS_RST(rst), .RD_IDX(idx), .RD_DATA(opnd), .SYSTEM_TICK(tick));

    // 10 MHz core clock
    always #50 clk = ~clk;

    // register index: upper bits, then low field bit, then the rest, even
    function automatic logic [8:0] fidx(input logic [2:0] u, input logic [4:0] f);
        return {u, f[0], f[4:1], 1'b0};
    endfunction
    function automatic logic [31:0] enc(input logic [5:0] op3, input logic [4:0] rd5,
        input logic [4:0] rs1, input logic [4:0] rs3, input logic [1:0] v,
        input logic [1:0] sz, input logic [4:0] rs2);
        return {OP_ARITH, rd5, op3, rs1, rs3, v, sz, rs2};
    endfunction
    task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one issue cycle; returns just after the edge that answers it
    task automatic issue(input logic [31:0] w, input sfto_prefix_t p);
        @(posedge clk);
        iv <= 1'b1;
        instr <= w;
        pfx <= p;
        @(posedge clk);
        iv <= 1'b0;
        pfx <= '0;
        #1;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        raddr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        raddr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // wake inputs are levels; one cycle is enough to sample
    task automatic pulse_wk(input int i);
        @(posedge clk);
        wk[i] <= 1'b1;
        @(posedge clk);
        wk[i] <= 1'b0;
        #1;
    endtask
    task automatic bar(input logic w);
        @(posedge clk);
        bupd <= 1'b1;
        bwin <= w;
        @(posedge clk);
        bupd <= 1'b0;
        #1;
    endtask

    task automatic t_regs();
        rreg(ADDR_CTRL, rv);
        chk("ctrl reset", CTRL_RESET, rv);
        wreg(4'h8, 32'hFFFF_FFFF);
        rreg(4'h8, rv);
        chk("unmapped", 0, rv);
        rreg(ADDR_STAT, rv);
        chk("status run", 0, rv);
    endtask
    task automatic t_fma_plain();
        issue(enc(OP3_IMPDEP_B, 5'h13, 5'h0B, 5'h15, 2'h0, 2'h2, 5'h07), 14'h2BBC);
        chk("fma valid", 1, dv);
        chk("fma src1", fidx(3'h5, 5'h0B), dec.basic.src1);
        chk("fma src2", fidx(3'h6, 5'h07), dec.basic.src2);
        chk("fma addend", fidx(3'h7, 5'h15), dec.basic.addend);
        chk("fma dst", fidx(3'h4, 5'h13), dec.basic.dst);
        chk("fma ext", 0, dec.ext_en);
    endtask
    task automatic t_fma_simd();
        for (int i = 0; i < 2; i++) begin
            issue(enc(OP3_IMPDEP_B, 5'h0D, 5'h06, 5'h11, 2'h1, 2'h2, 5'h1A),
                  {2'h3, 3'h5, 3'h2, 1'(i), 2'h3, 1'(i), 2'h1});
            chk("ext en", 1, dec.ext_en);
            chk("b src1", fidx(3'h5, 5'h06), dec.basic.src1);
            chk("e src1", fidx(i ? 3'h5 : 3'h1, 5'h06), dec.ext.src1);
            chk("e src2", fidx(3'h6, 5'h1A), dec.ext.src2);
            chk("b addend", fidx(3'h3, 5'h11), dec.basic.addend);
            chk("e addend", fidx(3'h7, 5'h11), dec.ext.addend);
            chk("b dst", fidx(3'h1, 5'h0D), dec.basic.dst);
            chk("e dst", fidx(3'h5, 5'h0D), dec.ext.dst);
            chk("e negate", i, dec.ext.negate);
            chk("b negate", 0, dec.basic.negate);
        end
    endtask
    task automatic t_quad();
        fpen <= 1'b0;
        issue(enc(OP3_IMPDEP_B, 5'h01, 5'h02, 5'h03, VAR_LOW, SIZE_QUAD, 5'h04), '0);
        chk("quad ill", 1, dec.ill_instr);
        chk("quad fpdis", 0, dec.fp_disabled);
        issue(enc(OP3_IMPDEP_B, 5'h01, 5'h02, 5'h03, VAR_LOW, 2'h2, 5'h04), '0);
        chk("fp off", 1, dec.fp_disabled);
        fpen <= 1'b1;
    endtask
    task automatic t_madd();
        logic [127:0] a, b, c, full;
        idx <= {fidx(3'h0, 5'h09), fidx(3'h0, 5'h05), fidx(3'h0, 5'h03)};
        a = {64'h0, ~{55'h0, fidx(3'h0, 5'h03)}};
        b = {64'h0, ~{55'h0, fidx(3'h0, 5'h05)}};
        c = {64'h0, ~{55'h0, fidx(3'h0, 5'h09)}};
        full = a * b + c;
        for (int v = 0; v < 2; v++) begin
            issue(enc(OP3_IMPDEP_B, 5'h0E, 5'h03, 5'h09, 2'(v), SIZE_INT, 5'h05), '0);
            chk("madd valid", 1, mv);
            chk("madd res", v ? full[127:64] : full[63:0], mres);
            chk("madd kind", v ? K_IMADD_HI : K_IMADD_LO, dec.kind);
            chk("madd dst", fidx(3'h0, 5'h0E), mdst);
            chk("madd fsr", 0, dec.fsr_update);
        end
        issue(enc(OP3_IMPDEP_B, 5'h0E, 5'h03, 5'h09, VAR_LOW, SIZE_INT, 5'h05), 14'h3004);
        chk("madd illact", 1, dec.ill_action);
        chk("madd cancel", 0, mv);
    endtask
    task automatic t_suspend();
        ie <= 1'b0;
        priv <= 1'b0;
        issue(W_SUS, '0);
        chk("susp priv", 1, dec.priv_trap);
        chk("susp nohalt", 0, halt);
        priv <= 1'b1;
        issue(W_SUS, '0);
        chk("susp ie", 1, dec.ie_set);
        chk("susp halt", 1, halt);
        issue(W_SLP, '0);
        chk("dropped", 0, dv);
        step(20);
        chk("susp stays", 1, halt);
        pulse_wk(2);
        chk("susp wake", 0, halt);
    endtask
    task automatic t_sleep();
        ie <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            issue(W_SLP, '0);
            chk("sleep halt", 1, halt);
            pulse_wk(i);
            chk("sleep wake", 0, halt);
        end
        ie <= 1'b0;
        issue(W_SLP, '0);
        ie <= 1'b1;
        rreg(ADDR_STAT, rv);
        chk("status sleep", 3'h2, rv[2:0]);
        pulse_wk(3);
        chk("ie off level", 1, halt);
        pulse_wk(0);
        chk("ie off reset", 0, halt);
    endtask
    task automatic t_timeout();
        int n;
        issue(W_SLP, '0);
        for (int i = 0; i < (TO - 1) * DIV; i++) begin
            chk("halt early", 1, halt);
            step(1);
        end
        n = 0;
        while (halt !== 1'b0 && n < 2 * TO * DIV) begin
            step(1);
            n++;
        end
        chk("timeout wake", 0, halt);
    endtask
    task automatic t_barrier();
        wreg(ADDR_CTRL, 32'h0);
        bar(1'b1);
        issue(W_SLP, '0);
        chk("no fall", 1, halt);
        bar(1'b0);
        chk("other flag", 1, halt);
        bar(1'b1);
        chk("window flag", 0, halt);
        wreg(ADDR_CTRL, 32'h1);
        bar(1'b1);
        rreg(ADDR_STAT, rv);
        chk("armed", 1, rv[3]);
        issue(W_SLP, '0);
        chk("fall thru", 0, halt);
        rreg(ADDR_STAT, rv);
        chk("disarmed", 4'h4, rv[3:0]);
    endtask

    task automatic results();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        {clk, iv, bupd, bwin, wr, rd, ie} = '0;
        {priv, fpen, rst} = 3'h7;
        {instr, wdata, wk, raddr, pfx, idx} = '0;
        num_errors = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_fma_plain();
        t_fma_simd();
        t_quad();
        t_madd();
        t_suspend();
        t_sleep();
        t_timeout();
        t_barrier();
        results();
    end

    // hang guard, well past the hundred or so cycles the tests need
    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule
